// file: design/pofr_flag_refresh.sv
// Operation
// - executing the set-pulse-count command sets the pulse-count-set flag.
// - speed, accel, trapezoid, stop/initialise and origin commands refresh flags when output starts or stops.
// - the reset flag changes the present value, clears overflow and at-origin, and sets no-origin.
// - flags are refreshed at power-up and when run operation starts or stops.
// - power-up clears present value and all flags except no-origin which is set; run start clears value and sets no-origin.
// - a limit stop with origin discarded clears present value and overflow and sets no-origin.
// - the clear-origin-at-limit setting chooses between keeping and discarding the origin on a limit stop.
// - a limit stop with origin kept keeps the value and clears busy, accel and interrupt-feed flags.
// - with limits always active and used for another function, the origin input asserting while busy with no origin or at a limit stop flags an error.
// - the stopped-error flag changes only on origin search, while busy with no origin, or in the limit error case, and clears at power-up.
// - the PWM flag is set only by the PWM command and cleared by stop/initialise, run stop and power-up.
// - the interrupt-feed flag follows the feed command and clears on stop/initialise, run edges, power-up, limit stops.
// - the pulse-count-set flag clears on speed, accel, feed, stop/initialise, run edges and power-up.
`include "pofr_defs.svh"
module pofr_flag_refresh
  import pofr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_limit_input,
  input wire logic i_origin_sensor_input,
  output logic [10:0] o_status,
  output logic [31:0] o_present_value
);
  logic lim_s1_q, lim_s2_q, lim_s3_q, org_s1_q, org_s2_q;
  logic [4:0] ctrl_q, ctrl_d;
  logic run_prev_q, resf_prev_q;
  logic [31:0] pv_q, pv_d, pvset_q, pvset_d;
  logic [10:0] st_q, st_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  pofr_apb_type apb_q, apb_d;
  logic wr, rd, cmd_wr, run_start, run_stop, res_rise, lim_rise, org_err;
  pofr_cmd_type cmd;
  logic arg;

  // input synchronisers
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      lim_s1_q <= 1'b0;
      lim_s2_q <= 1'b0;
      lim_s3_q <= 1'b0;
      org_s1_q <= 1'b0;
      org_s2_q <= 1'b0;
    end
    else
    begin
      lim_s1_q <= i_limit_input;
      lim_s2_q <= lim_s1_q;
      lim_s3_q <= lim_s2_q;
      org_s1_q <= i_origin_sensor_input;
      org_s2_q <= org_s1_q;
    end
  end

  // apb access phase, single answer registered one cycle later (one wait state)
  assign wr = i_psel && i_penable && i_pwrite && (apb_q == POFR_APB_IDLE);
  assign rd = i_psel && i_penable && !i_pwrite && (apb_q == POFR_APB_IDLE);
  assign cmd_wr = wr && (i_paddr == `POFR_CMD_OFF);
  assign cmd = cmd_wr ? pofr_cmd_type'(i_pwdata[`POFR_CMD_CODE_LSB +: `POFR_CMD_CODE_W])
    : POFR_CMD_NONE;
  assign arg = i_pwdata[`POFR_CMD_ARG_BIT];
  assign run_start = ctrl_q[`POFR_CTRL_RUN_BIT] && !run_prev_q;
  assign run_stop = !ctrl_q[`POFR_CTRL_RUN_BIT] && run_prev_q;
  assign res_rise = ctrl_q[`POFR_CTRL_RESETF_BIT] && !resf_prev_q;
  assign lim_rise = lim_s2_q && !lim_s3_q;
  assign org_err = org_s2_q && ctrl_q[`POFR_CTRL_LIM_ALWAYS_BIT]
    && ctrl_q[`POFR_CTRL_LIM_OTHER_BIT];

  always_comb
  begin
    apb_d = POFR_APB_IDLE;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    ctrl_d = ctrl_q;
    pvset_d = pvset_q;
    if ((wr || rd) && apb_q == POFR_APB_IDLE)
    begin
      apb_d = POFR_APB_DONE;
      pready_d = 1'b1;
      prdata_d = 32'h0000_0000;
      case (i_paddr)
        `POFR_CMD_OFF: ;
        `POFR_CTRL_OFF:
        begin
          if (wr)
            ctrl_d = i_pwdata[4:0];
          prdata_d = {27'h0, ctrl_q};
        end
        `POFR_PVSET_OFF:
        begin
          if (wr)
            pvset_d = i_pwdata;
          prdata_d = pvset_q;
        end
        `POFR_STAT_OFF: prdata_d = {21'h0, st_q};
        `POFR_PV_OFF: prdata_d = pv_q;
        default: pslverr_d = 1'b1;
      endcase
      if (wr && (i_paddr == `POFR_STAT_OFF || i_paddr == `POFR_PV_OFF))
        pslverr_d = 1'b1;
    end
  end

  // flag refresh; later events override earlier ones
  always_comb
  begin
    pv_d = pv_q;
    st_d = st_q;
    case (cmd)
      POFR_CMD_PULSE_COUNT: st_d[`POFR_ST_CNTSET] = 1'b1;
      POFR_CMD_SPEED, POFR_CMD_ACCEL, POFR_CMD_TRAPEZOID, POFR_CMD_INTERRUPT_FEED_CMD:
      begin
        pv_d = pvset_q;
        st_d[`POFR_ST_BUSY] = arg;
        st_d[`POFR_ST_DONE] = !arg;
        if (cmd != POFR_CMD_SPEED)
          st_d[`POFR_ST_ACCEL] = arg;
        st_d[`POFR_ST_ATORG] = (pvset_q == 32'h0000_0000);
        if (cmd != POFR_CMD_TRAPEZOID)
          st_d[`POFR_ST_CNTSET] = 1'b0;
        if (cmd == POFR_CMD_INTERRUPT_FEED_CMD)
          st_d[`POFR_ST_INTERRUPT_FEED_CMD] = arg;
      end
      POFR_CMD_STOP_INIT:
      begin
        pv_d = pvset_q;
        st_d[`POFR_ST_ACCEL] = 1'b0;
        st_d[`POFR_ST_OVF] = 1'b0;
        st_d[`POFR_ST_CNTSET] = 1'b0;
        st_d[`POFR_ST_BUSY] = 1'b0;
        st_d[`POFR_ST_NOORG] = 1'b0;
        st_d[`POFR_ST_ATORG] = (pvset_q == 32'h0000_0000);
        st_d[`POFR_ST_PWM] = 1'b0;
        st_d[`POFR_ST_INTERRUPT_FEED_CMD] = 1'b0;
      end
      POFR_CMD_ORIGIN_SEARCH:
      begin
        st_d[`POFR_ST_BUSY] = arg;
        st_d[`POFR_ST_ACCEL] = arg;
        st_d[`POFR_ST_OVF] = 1'b0;
        st_d[`POFR_ST_STOPERR] = 1'b0;
        st_d[`POFR_ST_NOORG] = arg;
      end
      POFR_CMD_ORIGIN_RETURN:
      begin
        st_d[`POFR_ST_BUSY] = arg;
        st_d[`POFR_ST_ACCEL] = arg;
        st_d[`POFR_ST_DONE] = !arg;
      end
      POFR_CMD_ORIGIN_FOUND:
      begin
        pv_d = 32'h0000_0000;
        st_d[`POFR_ST_BUSY] = 1'b0;
        st_d[`POFR_ST_ACCEL] = 1'b0;
        st_d[`POFR_ST_NOORG] = 1'b0;
        st_d[`POFR_ST_ATORG] = 1'b1;
      end
      POFR_CMD_DONE:
      begin
        pv_d = pvset_q;
        st_d[`POFR_ST_BUSY] = 1'b0;
        st_d[`POFR_ST_ACCEL] = 1'b0;
        st_d[`POFR_ST_DONE] = 1'b1;
        st_d[`POFR_ST_IFERR] = arg;
      end
      POFR_CMD_OVF: st_d[`POFR_ST_OVF] = 1'b1;
      POFR_CMD_PWM: st_d[`POFR_ST_PWM] = 1'b1;
      default: ;
    endcase
    if (st_q[`POFR_ST_BUSY] && st_q[`POFR_ST_NOORG] && org_err)
      st_d[`POFR_ST_STOPERR] = 1'b1;
    if (res_rise)
    begin
      pv_d = pvset_q;
      st_d[`POFR_ST_OVF] = 1'b0;
      st_d[`POFR_ST_ATORG] = 1'b0;
      st_d[`POFR_ST_NOORG] = 1'b1;
    end
    if (lim_rise)
    begin
      st_d[`POFR_ST_ACCEL] = 1'b0;
      st_d[`POFR_ST_BUSY] = 1'b0;
      st_d[`POFR_ST_INTERRUPT_FEED_CMD] = 1'b0;
      if (org_err)
        st_d[`POFR_ST_STOPERR] = 1'b1;
      if (ctrl_q[`POFR_CTRL_CLR_ORG_BIT])
      begin
        pv_d = 32'h0000_0000;
        st_d[`POFR_ST_OVF] = 1'b0;
        st_d[`POFR_ST_NOORG] = 1'b1;
      end
    end
    if (run_start || run_stop)
    begin
      st_d[`POFR_ST_ACCEL] = 1'b0;
      st_d[`POFR_ST_CNTSET] = 1'b0;
      st_d[`POFR_ST_DONE] = 1'b0;
      st_d[`POFR_ST_BUSY] = 1'b0;
      st_d[`POFR_ST_INTERRUPT_FEED_CMD] = 1'b0;
    end
    if (run_start)
    begin
      pv_d = 32'h0000_0000;
      st_d[`POFR_ST_OVF] = 1'b0;
      st_d[`POFR_ST_NOORG] = 1'b1;
      st_d[`POFR_ST_IFERR] = 1'b0;
    end
    if (run_stop)
      st_d[`POFR_ST_PWM] = 1'b0;
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      apb_q <= POFR_APB_IDLE;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      ctrl_q <= 5'h00;
      pvset_q <= 32'h0000_0000;
      run_prev_q <= 1'b0;
      resf_prev_q <= 1'b0;
      pv_q <= `POFR_PV_RESET;
      st_q <= `POFR_ST_RESET;
    end
    else
    begin
      apb_q <= apb_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      ctrl_q <= ctrl_d;
      pvset_q <= pvset_d;
      run_prev_q <= ctrl_q[`POFR_CTRL_RUN_BIT];
      resf_prev_q <= ctrl_q[`POFR_CTRL_RESETF_BIT];
      pv_q <= pv_d;
      st_q <= st_d;
    end
  end

  assign o_prdata = prdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_status = st_q;
  assign o_present_value = pv_q;

  a_pwm_set_only: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(st_q[`POFR_ST_PWM]) |-> $past(cmd) == POFR_CMD_PWM)
    else $error("pwm flag rose without pwm command");
  a_cntset_sets: assert property (@(posedge i_clk) disable iff (!i_nrst)
    cmd == POFR_CMD_PULSE_COUNT && !res_rise && !run_start && !run_stop
      |=> st_q[`POFR_ST_CNTSET])
    else $error("pulse count flag not set");
  a_run_start_clear: assert property (@(posedge i_clk) disable iff (!i_nrst)
    run_start |=> pv_q == 32'h0000_0000 && st_q[`POFR_ST_NOORG])
    else $error("run start did not clear value");
  a_reset_flag: assert property (@(posedge i_clk) disable iff (!i_nrst)
    res_rise && !lim_rise && !run_start |=> st_q[`POFR_ST_NOORG] && !st_q[`POFR_ST_ATORG]
      && !st_q[`POFR_ST_OVF])
    else $error("reset flag refresh wrong");
  a_limit_clr_org: assert property (@(posedge i_clk) disable iff (!i_nrst)
    lim_rise && ctrl_q[`POFR_CTRL_CLR_ORG_BIT] |=> pv_q == 32'h0000_0000
      && st_q[`POFR_ST_NOORG] && !st_q[`POFR_ST_OVF])
    else $error("limit with discarded origin wrong");
  a_limit_keep_org: assert property (@(posedge i_clk) disable iff (!i_nrst)
    lim_rise && !ctrl_q[`POFR_CTRL_CLR_ORG_BIT] && !res_rise && !run_start
      && cmd == POFR_CMD_NONE |=> pv_q == $past(pv_q) && !st_q[`POFR_ST_BUSY]
      && !st_q[`POFR_ST_INTERRUPT_FEED_CMD] && st_q[`POFR_ST_NOORG] == $past(st_q[`POFR_ST_NOORG]))
    else $error("limit with kept origin wrong");
  a_interrupt_feed_cmd_clear: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (run_start || run_stop || cmd == POFR_CMD_STOP_INIT) |=> !st_q[`POFR_ST_INTERRUPT_FEED_CMD])
    else $error("feed flag not cleared");
  a_cntset_clear: assert property (@(posedge i_clk) disable iff (!i_nrst)
    cmd == POFR_CMD_SPEED || cmd == POFR_CMD_ACCEL |=> !st_q[`POFR_ST_CNTSET])
    else $error("pulse count flag not cleared");
  a_stoperr_cause: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(st_q[`POFR_ST_STOPERR]) |-> $past(org_err))
    else $error("stop error without cause");
  a_pwm_clear: assert property (@(posedge i_clk) disable iff (!i_nrst)
    cmd == POFR_CMD_STOP_INIT || run_stop |=> !st_q[`POFR_ST_PWM])
    else $error("pwm flag not cleared");
  a_stop_init_refresh: assert property (@(posedge i_clk) disable iff (!i_nrst)
    cmd == POFR_CMD_STOP_INIT && !lim_rise && !run_start
      |=> !st_q[`POFR_ST_BUSY] && pv_q == $past(pvset_q))
    else $error("stop command refresh wrong");
  a_interrupt_feed_cmd_follow: assert property (@(posedge i_clk) disable iff (!i_nrst)
    cmd == POFR_CMD_INTERRUPT_FEED_CMD && !lim_rise && !run_start && !run_stop
      |=> st_q[`POFR_ST_INTERRUPT_FEED_CMD] == $past(arg))
    else $error("feed flag does not follow command");
  a_apb_answer: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_psel && i_penable && !o_pready |=> o_pready)
    else $error("apb answer late");
endmodule : pofr_flag_refresh

// file: design/pofr_defs.svh
`ifndef POFR_DEFS_SVH
`define POFR_DEFS_SVH
// register byte offsets
`define POFR_CMD_OFF 12'h000
`define POFR_CTRL_OFF 12'h004
`define POFR_PVSET_OFF 12'h008
`define POFR_STAT_OFF 12'h00C
`define POFR_PV_OFF 12'h010
// command register fields
`define POFR_CMD_CODE_LSB 0
`define POFR_CMD_CODE_W 4
`define POFR_CMD_ARG_BIT 4
// control register bits
`define POFR_CTRL_RUN_BIT 0
`define POFR_CTRL_RESETF_BIT 1
`define POFR_CTRL_CLR_ORG_BIT 2
`define POFR_CTRL_LIM_ALWAYS_BIT 3
`define POFR_CTRL_LIM_OTHER_BIT 4
// status bit positions
`define POFR_ST_ACCEL 0
`define POFR_ST_OVF 1
`define POFR_ST_CNTSET 2
`define POFR_ST_DONE 3
`define POFR_ST_BUSY 4
`define POFR_ST_NOORG 5
`define POFR_ST_ATORG 6
`define POFR_ST_STOPERR 7
`define POFR_ST_PWM 8
`define POFR_ST_INTERRUPT_FEED_CMD 9
`define POFR_ST_IFERR 10
`define POFR_ST_W 11
`define POFR_PV_RESET 32'h0000_0000
`define POFR_ST_RESET 11'h020
`endif

// file: design/pofr_pkg.sv
package pofr_pkg;
  typedef enum logic [3:0]
  {
    POFR_CMD_NONE = 4'h0,
    POFR_CMD_PULSE_COUNT = 4'h1,
    POFR_CMD_SPEED = 4'h2,
    POFR_CMD_ACCEL = 4'h3,
    POFR_CMD_TRAPEZOID = 4'h4,
    POFR_CMD_STOP_INIT = 4'h5,
    POFR_CMD_ORIGIN_SEARCH = 4'h6,
    POFR_CMD_ORIGIN_RETURN = 4'h7,
    POFR_CMD_INTERRUPT_FEED_CMD = 4'h8,
    POFR_CMD_PWM = 4'h9,
    POFR_CMD_DONE = 4'hA,
    POFR_CMD_ORIGIN_FOUND = 4'hB,
    POFR_CMD_OVF = 4'hC
  } pofr_cmd_type;
  typedef enum logic [1:0]
  {
    POFR_APB_IDLE = 2'b01,
    POFR_APB_DONE = 2'b10
  } pofr_apb_type;
endpackage : pofr_pkg

// file: sim/pofr_flag_refresh_tb_top.sv
`include "pofr_defs.svh"
module pofr_flag_refresh_tb_top
  import pofr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [10:0] st_accel = 11'h1 << `POFR_ST_ACCEL;
  localparam logic [10:0] st_ovf = 11'h1 << `POFR_ST_OVF;
  localparam logic [10:0] st_cnt = 11'h1 << `POFR_ST_CNTSET;
  localparam logic [10:0] st_busy = 11'h1 << `POFR_ST_BUSY;
  localparam logic [10:0] st_noorg = 11'h1 << `POFR_ST_NOORG;
  localparam logic [10:0] st_atorg = 11'h1 << `POFR_ST_ATORG;
  localparam logic [10:0] st_stoperr = 11'h1 << `POFR_ST_STOPERR;
  localparam logic [10:0] st_pwm = 11'h1 << `POFR_ST_PWM;
  localparam logic [10:0] st_interrupt_feed_cmd = 11'h1 << `POFR_ST_INTERRUPT_FEED_CMD;
  localparam logic [10:0] st_done = 11'h1 << `POFR_ST_DONE;
  localparam logic [10:0] st_iferr = 11'h1 << `POFR_ST_IFERR;
  logic i_clk;
  logic i_nrst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic limit;
  logic origin;
  logic [10:0] status;
  logic [31:0] pv;
  logic [31:0] rd;
  logic err;
  int miscompares;
  int tests_run;
  pofr_flag_refresh dut
  (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_psel(psel),
    .i_penable(penable),
    .i_pwrite(pwrite),
    .i_paddr(paddr),
    .i_pwdata(pwdata),
    .o_prdata(prdata),
    .o_pready(pready),
    .o_pslverr(pslverr),
    .i_limit_input(limit),
    .i_origin_sensor_input(origin),
    .o_status(status),
    .o_present_value(pv)
  );
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task finish_test;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
      begin
        $display("== PASSED ==");
      end
      else
      begin
        $display("== FAILED ==");
      end
      $finish;
    end
  endtask : finish_test
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    begin
      tests_run++;
      if (seen !== exp)
      begin
        miscompares++;
        $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask : check
  // one transfer; holds the request until pready is seen at an edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    begin
      n = 0;
      @(posedge i_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk);
      penable <= 1'b1;
      @(posedge i_clk);
      while (pready !== 1'b1)
      begin
        n++;
        if (n > 20)
        begin
          miscompares++;
          finish_test();
        end
        @(posedge i_clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb
  task cmd(input pofr_cmd_type c, input logic arg);
    apb(1'b1, `POFR_CMD_OFF, {27'h0, arg, c});
  endtask : cmd
  task rdst(input string name, input logic [10:0] mask, input logic [10:0] exp);
    begin
      apb(1'b0, `POFR_STAT_OFF, 32'h0);
      check(name, rd & {21'h0, mask}, {21'h0, exp});
      check(name, {21'h0, status & mask}, {21'h0, exp});
    end
  endtask : rdst
  task done(input string name);
    $display("test %s finished", name);
  endtask : done
  initial
  begin
    repeat (100000) @(posedge i_clk);
    miscompares++;
    finish_test();
  end
  initial
  begin
    i_nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    limit = 1'b0;
    origin = 1'b0;
    miscompares = 0;
    tests_run = 0;
    repeat (8) @(posedge i_clk);
    i_nrst <= 1'b1;
    check("pv powerup", pv, 32'h0);
    rdst("powerup", 11'h7FF, 11'h020);
    apb(1'b0, 12'h0FC, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    apb(1'b1, `POFR_STAT_OFF, 32'hFFFF_FFFF);
    check("ro err", {31'h0, err}, 32'h1);
    rdst("ro stat", 11'h7FF, 11'h020);
    done("powerup_bus");
    apb(1'b1, `POFR_PVSET_OFF, 32'h0000_55AA);
    apb(1'b1, `POFR_CTRL_OFF, 32'h1);
    cmd(POFR_CMD_PWM, 1'b1);
    cmd(POFR_CMD_PULSE_COUNT, 1'b1);
    rdst("cnt pwm", st_cnt | st_pwm, st_cnt | st_pwm);
    cmd(POFR_CMD_OVF, 1'b1);
    cmd(POFR_CMD_STOP_INIT, 1'b1);
    rdst("init", st_pwm | st_cnt | st_busy | st_noorg | st_ovf, 11'h0);
    check("pv init", pv, 32'h0000_55AA);
    cmd(POFR_CMD_PULSE_COUNT, 1'b1);
    cmd(POFR_CMD_SPEED, 1'b1);
    rdst("speed", st_cnt | st_busy, st_busy);
    cmd(POFR_CMD_INTERRUPT_FEED_CMD, 1'b1);
    rdst("interrupt_feed_cmd", st_interrupt_feed_cmd, st_interrupt_feed_cmd);
    cmd(POFR_CMD_PULSE_COUNT, 1'b1);
    cmd(POFR_CMD_ACCEL, 1'b1);
    rdst("accel", st_cnt | st_accel | st_busy, st_accel | st_busy);
    cmd(POFR_CMD_PULSE_COUNT, 1'b1);
    cmd(POFR_CMD_TRAPEZOID, 1'b1);
    rdst("trapezoid", st_cnt | st_busy, st_cnt | st_busy);
    done("commands");
    limit <= 1'b1;
    repeat (5) @(posedge i_clk);
    rdst("limit keep", st_busy | st_interrupt_feed_cmd | st_accel | st_noorg, 11'h0);
    check("pv limit keep", pv, 32'h0000_55AA);
    limit <= 1'b0;
    apb(1'b1, `POFR_CTRL_OFF, 32'h5);
    cmd(POFR_CMD_SPEED, 1'b1);
    cmd(POFR_CMD_OVF, 1'b1);
    limit <= 1'b1;
    repeat (5) @(posedge i_clk);
    rdst("limit clear", st_busy | st_ovf | st_noorg, st_noorg);
    check("pv limit clear", pv, 32'h0);
    limit <= 1'b0;
    done("limit");
    cmd(POFR_CMD_STOP_INIT, 1'b1);
    apb(1'b1, `POFR_PVSET_OFF, 32'h0000_0077);
    cmd(POFR_CMD_ORIGIN_FOUND, 1'b1);
    cmd(POFR_CMD_OVF, 1'b1);
    apb(1'b1, `POFR_CTRL_OFF, 32'h7);
    rdst("reset flag", st_noorg | st_atorg | st_ovf, st_noorg);
    check("pv reset flag", pv, 32'h0000_0077);
    cmd(POFR_CMD_STOP_INIT, 1'b1);
    cmd(POFR_CMD_PWM, 1'b1);
    cmd(POFR_CMD_INTERRUPT_FEED_CMD, 1'b1);
    cmd(POFR_CMD_PULSE_COUNT, 1'b1);
    cmd(POFR_CMD_DONE, 1'b1);
    rdst("done", st_done | st_busy | st_iferr, st_done | st_iferr);
    cmd(POFR_CMD_ORIGIN_RETURN, 1'b1);
    apb(1'b1, `POFR_CTRL_OFF, 32'h0);
    rdst("run stop", st_pwm | st_cnt | st_interrupt_feed_cmd | st_busy | st_noorg, 11'h0);
    check("pv run stop", pv, 32'h0000_0077);
    rdst("run stop err", st_accel | st_iferr, st_iferr);
    apb(1'b1, `POFR_CTRL_OFF, 32'h1);
    rdst("run start", st_noorg | st_cnt | st_busy | st_iferr, st_noorg);
    check("pv run start", pv, 32'h0);
    done("reset_run");
    apb(1'b1, `POFR_CTRL_OFF, 32'h19);
    cmd(POFR_CMD_ORIGIN_SEARCH, 1'b1);
    origin <= 1'b1;
    repeat (5) @(posedge i_clk);
    rdst("origin error", st_stoperr, st_stoperr);
    origin <= 1'b0;
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    rdst("power cycle", 11'h7FF, 11'h020);
    check("pv power cycle", pv, 32'h0);
    done("origin_power");
    finish_test();
  end
endmodule : pofr_flag_refresh_tb_top
